// ### lookup_table_status_irq.sv
// Summary of operation
// - Sixteen-bit read-only service summary register
// - Summary bit n belongs to table n
// - Summary bit high while table needs service
// - Disabled table discards cells, no flags, uncounted
// - Up to sixteen ports: port n uses table n
// - Above sixteen: ports 2k, 2k+1 share k
// - Misroute flag bit 4 on A=I=0
// - Channel range flag bit 5 on VCI excess
// - Path range flag bit 6 on unmasked VPI
// - Enables bits 10-12 gate matching flag interrupts
// - Request holds until flag or enable cleared
// - Reserved fields read zero, reset zero
`timescale 1ns/1ps
module lookup_table_status_irq
#(
  parameter int TABLES = 16
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ltsi_pkg::ltsi_cell_t cellIn,
  output logic cellAccepted,
  output logic cellDiscarded,
  output logic irqRequest
);
  if (TABLES != ltsi_pkg::NUM_TABLES)
  begin : gBadTables
    $error("TABLES must be sixteen");
  end

  logic [15:0] cfg [16];
  logic [15:0] summary;
  logic [15:0] enableVec;
  logic [15:0] checkVec;
  logic wideMode;
  ltsi_pkg::ltsi_check_t res;

  // Write channel state
  logic awHeld;
  logic wHeld;
  logic [31:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic doWrite;
  logic [11:0] wIndex;
  logic wIsTable;
  logic wIsCtrl;
  logic [3:0] wTable;
  logic [15:0] wLow;
  logic [15:0] wLaneMask;

  // Read channel state
  logic [11:0] rIndex;
  logic rIsTable;
  logic rIsSummary;
  logic rIsCtrl;
  logic [3:0] rTable;
  logic [31:0] next_rdata;
  logic rHit;

  function automatic logic [11:0] word_index(input logic [31:0] addr);
    word_index = addr[13:2];
  endfunction

  function automatic logic in_table_range(input logic [11:0] idx);
    logic [11:0] rel;
    rel = idx - ltsi_pkg::TABLE0_INDEX;
    in_table_range = idx >= ltsi_pkg::TABLE0_INDEX && !rel[0] &&
      rel < 12'(ltsi_pkg::NUM_TABLES * 2);
  endfunction

  function automatic logic [3:0] table_of(input logic [11:0] idx);
    logic [11:0] rel;
    rel = idx - ltsi_pkg::TABLE0_INDEX;
    table_of = rel[4:1];
  endfunction

  ltsi_cell_check cellCheck
  (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .wideMode(wideMode),
    .tableEnable(enableVec),
    .vpiCheck(checkVec),
    .cellIn(cellIn),
    .result(res)
  );

  // Write address decode; byte address is four times the index
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign wIndex = word_index(awAddr);
  assign wIsTable = in_table_range(wIndex);
  assign wIsCtrl = wIndex == ltsi_pkg::CTRL_INDEX;
  assign wTable = table_of(wIndex);
  assign wLow = wData[15:0];
  assign wLaneMask = {{8{wStrb[1]}}, {8{wStrb[0]}}};

  // Read decode
  assign s_axi_arready = !s_axi_rvalid;
  assign rIndex = word_index(s_axi_araddr);
  assign rIsTable = in_table_range(rIndex);
  assign rIsSummary = rIndex == ltsi_pkg::SUMMARY_INDEX;
  assign rIsCtrl = rIndex == ltsi_pkg::CTRL_INDEX;
  assign rTable = table_of(rIndex);
  assign rHit = rIsTable || rIsSummary || rIsCtrl;
  assign next_rdata = rIsTable ? {16'h0000, cfg[rTable]} :
    rIsSummary ? {16'h0000, summary} :
    rIsCtrl ? {30'h0000_0000, wideMode, 1'b0} : 32'h0000_0000;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 32'h0000_0000;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      else if (doWrite)
        awHeld <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      else if (doWrite)
        wHeld <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ltsi_pkg::RESP_OKAY;
    end
    else if (doWrite)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wIsTable || wIsCtrl) ? ltsi_pkg::RESP_OKAY :
        ltsi_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ltsi_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= rHit ? ltsi_pkg::RESP_OKAY : ltsi_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Port-count mode; the per-table VPI check settings are tied on here, not in this map
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      wideMode <= 1'b0;
    else if (doWrite && wIsCtrl && wStrb[0])
      wideMode <= wData[0];
  end

  // Flags are cleared by writing one; a new event in the same cycle wins
  genvar g;
  generate
    for (g = 0; g < ltsi_pkg::NUM_TABLES; g++)
    begin : gTable
      logic hitHere;
      logic writeHere;
      logic [15:0] setBits;
      logic [15:0] clrBits;
      logic [15:0] cfgBits;
      logic [15:0] next_cfg;
      assign hitHere = res.valid && res.tableIdx == 4'(g);
      assign writeHere = doWrite && wIsTable && wTable == 4'(g);
      assign setBits = hitHere ? {9'h000, res.pathRange,
        res.chanRange, res.misroute, 4'h0} : 16'h0000;
      assign clrBits = writeHere ?
        (wLow & wLaneMask & ltsi_pkg::TABLE_FLAG_MASK) : 16'h0000;
      assign cfgBits = writeHere ?
        ((cfg[g] & ~(wLaneMask & ltsi_pkg::TABLE_WR_MASK)) |
         (wLow & wLaneMask & ltsi_pkg::TABLE_WR_MASK)) : cfg[g];
      assign next_cfg = ((cfgBits & ltsi_pkg::TABLE_WR_MASK) |
        (cfg[g] & ltsi_pkg::TABLE_FLAG_MASK & ~clrBits) | setBits) &
        (ltsi_pkg::TABLE_WR_MASK | ltsi_pkg::TABLE_FLAG_MASK);
      always_ff @(posedge sys_clk)
      begin
        if (!reset_n)
          cfg[g] <= ltsi_pkg::TABLE_RESET;
        else
          cfg[g] <= next_cfg;
      end
      assign enableVec[g] = cfg[g][ltsi_pkg::EN_BIT];
      assign checkVec[g] = 1'b1;
      assign summary[g] =
        (cfg[g][ltsi_pkg::MIS_BIT] && cfg[g][ltsi_pkg::MIS_IE_BIT]) ||
        (cfg[g][ltsi_pkg::VCI_BIT] && cfg[g][ltsi_pkg::VCI_IE_BIT]) ||
        (cfg[g][ltsi_pkg::VPI_BIT] && cfg[g][ltsi_pkg::VPI_IE_BIT]);
    end
  endgenerate

  // Level request, drops only when software clears a flag or enable
  assign irqRequest = |summary;
  assign cellAccepted = res.valid && !res.discard;
  assign cellDiscarded = res.valid && res.discard;

  AST_DISABLED_NO_FLAG: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    cellIn.valid &&
    !enableVec[wideMode ? cellIn.port[4:1] : cellIn.port[3:0]]
    |=> cellDiscarded && !res.misroute && !res.chanRange && !res.pathRange)
    else $error("disabled table produced a flag");

  AST_NARROW_MAP: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    cellIn.valid && !wideMode |=> res.tableIdx == $past(cellIn.port[3:0]))
    else $error("narrow port mapping wrong");

  AST_WIDE_MAP: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    cellIn.valid && wideMode |=> res.tableIdx == $past(cellIn.port[4:1]))
    else $error("wide port mapping wrong");

  AST_MISROUTE_SET: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    res.valid && res.misroute |=>
    cfg[$past(res.tableIdx)][ltsi_pkg::MIS_BIT])
    else $error("misroute flag not set");

  AST_CHANNEL_SET: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    cellIn.valid &&
    enableVec[wideMode ? cellIn.port[4:1] : cellIn.port[3:0]] &&
    cellIn.vci > cellIn.vciLimit |=> res.chanRange)
    else $error("channel range not detected");

  // Check setting is tied on, so any unmasked path bit must flag
  AST_PATH_SET: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    cellIn.valid &&
    enableVec[wideMode ? cellIn.port[4:1] : cellIn.port[3:0]] &&
    checkVec[wideMode ? cellIn.port[4:1] : cellIn.port[3:0]] &&
    |(cellIn.vpi & ~cellIn.vpiMask) |=> res.pathRange)
    else $error("path range not detected");

  AST_SUMMARY_READ: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    s_axi_rvalid && $past(s_axi_arvalid && s_axi_arready && rIsSummary)
    |-> s_axi_rdata == {16'h0000, $past(summary)})
    else $error("summary read data wrong");

  AST_SUMMARY_CLEAN: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    summary == 16'h0000 |-> !irqRequest)
    else $error("request without summary");

  AST_IRQ_HOLDS: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    irqRequest && !doWrite |=> irqRequest)
    else $error("request dropped without software");

  AST_RESERVED_ZERO: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    s_axi_rvalid && $past(s_axi_arvalid && s_axi_arready && rIsTable) |->
    s_axi_rdata[15:13] == 3'h0 &&
    s_axi_rdata[9:7] == 3'h0 && s_axi_rdata[3:1] == 3'h0)
    else $error("reserved bits nonzero");
endmodule

// ### ltsi_cell_check.sv
`timescale 1ns/1ps
module ltsi_cell_check
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic wideMode,
  input wire logic [15:0] tableEnable,
  input wire logic [15:0] vpiCheck,
  input wire ltsi_pkg::ltsi_cell_t cellIn,
  output ltsi_pkg::ltsi_check_t result
);
  logic [3:0] tableIdx;
  logic enabled;
  logic misHit;
  logic vciHit;
  logic vpiHit;

  ltsi_port_map portMap
  (
    .wideMode(wideMode),
    .port(cellIn.port),
    .tableIdx(tableIdx)
  );

  assign enabled = tableEnable[tableIdx];
  assign misHit = !cellIn.recA && !cellIn.recI;
  assign vciHit = cellIn.vci > cellIn.vciLimit;
  assign vpiHit = vpiCheck[tableIdx] &&
    |(cellIn.vpi & ~cellIn.vpiMask);

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      result <= '0;
    else
    begin
      result.valid <= cellIn.valid;
      result.tableIdx <= tableIdx;
      result.discard <= cellIn.valid && !enabled;
      result.misroute <= cellIn.valid && enabled && misHit;
      result.chanRange <= cellIn.valid && enabled && vciHit;
      result.pathRange <= cellIn.valid && enabled && vpiHit;
    end
  end
endmodule

// ### ltsi_pkg.sv
package ltsi_pkg;
  localparam int NUM_TABLES = 16;
  localparam int REG_W = 16;
  // Printed offsets are halfword offsets, so each is kept as an index
  localparam logic [11:0] SUMMARY_INDEX = 12'h030E;
  localparam logic [11:0] TABLE0_INDEX = 12'h0320;
  localparam logic [11:0] TABLE_INDEX_STEP = 12'h0002;
  localparam logic [11:0] CTRL_INDEX = 12'h0340;
  localparam int EN_BIT = 0;
  localparam int MIS_BIT = 4;
  localparam int VCI_BIT = 5;
  localparam int VPI_BIT = 6;
  localparam int MIS_IE_BIT = 10;
  localparam int VCI_IE_BIT = 11;
  localparam int VPI_IE_BIT = 12;
  localparam logic [15:0] TABLE_RESET = 16'h0000;
  localparam logic [15:0] SUMMARY_RESET = 16'h0000;
  localparam logic [15:0] TABLE_WR_MASK = 16'h1C01;
  localparam logic [15:0] TABLE_FLAG_MASK = 16'h0070;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic valid;
    logic [4:0] port;
    logic recA;
    logic recI;
    logic [15:0] vci;
    logic [15:0] vciLimit;
    logic [11:0] vpi;
    logic [11:0] vpiMask;
  } ltsi_cell_t;

  typedef struct packed {
    logic valid;
    logic [3:0] tableIdx;
    logic discard;
    logic misroute;
    logic chanRange;
    logic pathRange;
  } ltsi_check_t;

  typedef struct packed {
    logic [3:0] tableIdx;
    logic mis;
    logic vci;
    logic vpi;
  } ltsi_event_t;
endpackage

// ### ltsi_port_map.sv
`timescale 1ns/1ps
module ltsi_port_map
(
  input wire logic wideMode,
  input wire logic [4:0] port,
  output logic [3:0] tableIdx
);
  // Above sixteen ports an even/odd pair shares one table
  assign tableIdx = wideMode ? port[4:1] : port[3:0];
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic sys_clk, reset_n;
  logic [31:0] awAddr, wData, arAddr, rData, lfsr, d;
  logic [3:0] wStrb;
  logic awValid, awReady, wValid, wReady, bValid, bReady;
  logic arValid, arReady, rValid, rReady, wide;
  logic [1:0] bResp, rResp, r;
  ltsi_pkg::ltsi_cell_t cellIn;
  logic cellAccepted, cellDiscarded, irqRequest;
  int failures, comparisons, accCnt, disCnt, expAcc, expDis;
  int tblReg[16];

  lookup_table_status_irq DUT
  (
    .sys_clk(sys_clk), .reset_n(reset_n),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .cellIn(cellIn), .cellAccepted(cellAccepted),
    .cellDiscarded(cellDiscarded), .irqRequest(irqRequest)
  );

  initial
  begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Pulses are counted, not sampled, so the exact latency stays free
  always @(posedge sys_clk)
  begin
    if (cellAccepted === 1'b1) accCnt++;
    if (cellDiscarded === 1'b1) disCnt++;
  end

  function logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  function logic [31:0] tAddr(input int n);
    return {18'h0_0000, ltsi_pkg::TABLE0_INDEX + 12'(2 * n), 2'b00};
  endfunction

  task end_sim();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Ready is sampled at the falling edge where the inputs are settled
  task axiWr(input logic [31:0] a, input logic [31:0] v);
    logic ah, wh, bh;
    awAddr <= a;
    wData <= v;
    awValid <= 1;
    wValid <= 1;
    bh = 0;
    while (!bh)
    begin
      @(negedge sys_clk);
      ah = awValid & awReady;
      wh = wValid & wReady;
      bh = (bValid === 1'b1);
      r = bResp;
      @(posedge sys_clk);
      if (ah) awValid <= 0;
      if (wh) wValid <= 0;
    end
  endtask

  task axiRd(input logic [31:0] a);
    logic ah, rh;
    arAddr <= a;
    arValid <= 1;
    rh = 0;
    while (!rh)
    begin
      @(negedge sys_clk);
      ah = arValid & arReady;
      rh = (rValid === 1'b1);
      d = rData;
      r = rResp;
      @(posedge sys_clk);
      if (ah) arValid <= 0;
    end
  endtask

  task wrTables();
    logic [31:0] v;
    for (int n = 0; n < 16; n++)
    begin
      v = rnd();
      axiWr(tAddr(n), v);
      check(r, ltsi_pkg::RESP_OKAY);
      tblReg[n] = (v & 32'h0000_1c01) | (tblReg[n] & 32'h0000_0070 & ~v);
    end
  endtask

  task checkAll();
    int s;
    s = 0;
    for (int n = 0; n < 16; n++)
    begin
      axiRd(tAddr(n));
      check(d, tblReg[n]);
      if (((tblReg[n] >> 6) & tblReg[n] & 32'h0000_0070) != 0) s |= 1 << n;
    end
    axiRd({18'h0_0000, ltsi_pkg::SUMMARY_INDEX, 2'b00});
    check(d, s);
    check(r, ltsi_pkg::RESP_OKAY);
    @(negedge sys_clk);
    check(irqRequest, s != 0);
    @(posedge sys_clk);
  endtask

  // Back-to-back cells; the caller drops valid after the burst
  task sendCell(input logic [4:0] p, input logic [31:0] x);
    ltsi_pkg::ltsi_cell_t c;
    int t;
    c = '0;
    c.valid = 1;
    c.port = p;
    c.recA = x[0];
    c.recI = x[1];
    c.vci = x[31:16];
    c.vciLimit = 16'(rnd());
    c.vpi = x[2] ? 12'hfff : 12'h000;
    c.vpiMask = 12'h0f0;
    t = wide ? int'(p >> 1) : int'(p);
    if (tblReg[t][0])
    begin
      tblReg[t] |= {x[2], c.vci > c.vciLimit, !x[0] && !x[1], 4'h0};
      expAcc++;
    end
    else
      expDis++;
    cellIn <= c;
    @(posedge sys_clk);
  endtask

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    $display("ERROR %0t timeout", $time);
    end_sim;
  end

  initial
  begin
    lfsr = 32'h642f_d9d1;
    {failures, comparisons, accCnt, disCnt, expAcc, expDis} = '0;
    reset_n = 0;
    {awAddr, wData, arAddr} = '0;
    {awValid, wValid, arValid, wide} = '0;
    bReady = 1;
    rReady = 1;
    wStrb = 4'hf;
    cellIn = '0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1;
    @(posedge sys_clk);
    checkAll();
    axiRd(32'h0000_0000);
    check(r, ltsi_pkg::RESP_SLVERR);
    check(d, 32'h0000_0000);
    axiWr(32'h0000_0004, 32'hffff_ffff);
    check(r, ltsi_pkg::RESP_SLVERR);
    for (int m = 0; m < 2; m++)
    begin
      wide = m[0];
      axiWr({18'h0_0000, ltsi_pkg::CTRL_INDEX, 2'b00}, m);
      axiRd({18'h0_0000, ltsi_pkg::CTRL_INDEX, 2'b00});
      check(d, {30'h0000_0000, m[0], 1'b0});
      wrTables();
      checkAll();
      for (int k = 0; k < 48; k++)
      begin
        d = rnd();
        sendCell(wide ? d[12:8] : {1'b0, d[11:8]}, d);
      end
      cellIn.valid <= 0;
      repeat (4) @(posedge sys_clk);
      check(accCnt, expAcc);
      check(disCnt, expDis);
      checkAll();
      wrTables();
      checkAll();
    end
    end_sim;
  end
endmodule
